// ### common/dma_cmd_pkg.sv
package dma_cmd_pkg;
    // Register byte offsets
    localparam logic [11:0] global_command_offset = 12'h000;
    localparam logic [11:0] global_mode_offset    = 12'h004;
    localparam logic [11:0] global_status_offset  = 12'h008;
    localparam logic [11:0] channel_cfg_offset    = 12'h00c;
    localparam logic [11:0] desc_ptr_offset       = 12'h010;

    // Global command fields
    localparam int action_request_bit     = 0;
    localparam int irq_mask_bit           = 9;
    localparam int tx_poll_lsb            = 10;
    localparam int tx_queue_cfg_lsb       = 24;
    localparam int rx_queue_cfg_lsb       = 28;
    localparam int config_queue_cfg_bit   = 21;
    localparam logic [31:0] command_rw_mask = 32'hff20_0200;
    localparam logic [31:0] command_reset   = 32'h0000_0200;

    // Global mode fields
    localparam int dma_control_select_bit = 0;

    // Global status fields
    localparam int ar_done_bit = 0;
    localparam int ar_fail_bit = 1;

    // Channel configuration: per channel, rx reset, tx reset, rx init, tx init
    localparam int chan_cfg_width = 4;
    localparam int chan_count     = 4;

    // Descriptor layout
    localparam int hold_bit = 31;

    // Action request takes this many cycles to execute
    localparam logic [3:0] ar_exec_cycles = 4'h4;

    typedef enum logic [4:0] {
        tx_run      = 5'b00001,
        tx_fetch_w0 = 5'b00010,
        tx_fetch_w1 = 5'b00100,
        tx_held     = 5'b01000,
        tx_poll     = 5'b10000
    } tx_state_e;
endpackage : dma_cmd_pkg

// ### hdl/tx_poll_channel.sv
`timescale 1ns/10ps
module tx_poll_channel (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        hold_mode,
    input  wire logic        poll_cmd,
    input  wire logic        desc_fetch_start,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    output logic             mem_req,
    output logic             mem_word,
    output logic             held,
    output logic             advance,
    output logic [31:0]      next_desc
);
    dma_cmd_pkg::tx_state_e state;
    logic                   hold_seen;
    logic                   fetch_wait;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= dma_cmd_pkg::tx_run;
            hold_seen <= 1'b0;
            next_desc <= 32'h0000_0000;
            advance   <= 1'b0;
        end else begin
            advance <= 1'b0;
            unique case (state)
                dma_cmd_pkg::tx_run: begin
                    if (desc_fetch_start) begin
                        state <= dma_cmd_pkg::tx_fetch_w0;
                    end
                end
                dma_cmd_pkg::tx_fetch_w0, dma_cmd_pkg::tx_poll: begin
                    if (mem_ack) begin
                        hold_seen <= mem_rdata[dma_cmd_pkg::hold_bit];
                        state     <= dma_cmd_pkg::tx_fetch_w1;
                    end
                end
                dma_cmd_pkg::tx_fetch_w1: begin
                    if (mem_ack) begin
                        next_desc <= mem_rdata;
                        if (hold_seen && hold_mode) begin
                            state <= dma_cmd_pkg::tx_held;
                        end else begin
                            advance <= 1'b1;
                            state   <= dma_cmd_pkg::tx_run;
                        end
                    end
                end
                dma_cmd_pkg::tx_held: begin
                    // Poll outside the held state never reaches here
                    if (poll_cmd && hold_mode) begin
                        state <= dma_cmd_pkg::tx_poll;
                    end
                end
            endcase
        end
    end

    // One request per word: a slow memory must not see repeated requests
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_req    <= 1'b0;
            mem_word   <= 1'b0;
            held       <= 1'b0;
            fetch_wait <= 1'b0;
        end else begin
            mem_req  <= 1'b0;
            mem_word <= 1'b0;
            held     <= (state == dma_cmd_pkg::tx_held);
            if (mem_ack) begin
                fetch_wait <= 1'b0;
            end else if (mem_req) begin
                fetch_wait <= 1'b1;
            end
            if (!mem_req && !fetch_wait) begin
                if (state == dma_cmd_pkg::tx_fetch_w0 || state == dma_cmd_pkg::tx_poll) begin
                    mem_req <= ~mem_ack;
                end else if (state == dma_cmd_pkg::tx_fetch_w1) begin
                    mem_req  <= ~mem_ack;
                    mem_word <= 1'b1;
                end
            end
        end
    end
endmodule : tx_poll_channel

// ### hdl/dma_global_command_logic.sv
// Function
// - Poll bits self-clear; honoured only while mode select bit is zero.
// - Without poll, channel stops when descriptor pause flag is set, only while mode select bit is zero.
// - Poll while paused refetches descriptor words 0 and 1.
// - Cleared pause flag on refetch moves on to next descriptor.
// - Poll to a channel not paused is ignored entirely.
// - Poll bits 13..10 for channels 3..0, reset zero.
// - Action request mask bit 9, read/write, resets to one.
// - Bits 8 to 1 reserved, read zero.
// - Action request bit 0 validates queue and channel command bits.
// - Configuring a queue reads its base and length registers.
// - Action request outcome is reported in global status.
`timescale 1ns/10ps
module dma_global_command_logic (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [3:0]  desc_fetch_start,
    input  wire logic [3:0]  mem_ack,
    input  wire logic [31:0] mem_rdata,
    output logic [3:0]       mem_req,
    output logic [3:0]       mem_word,
    output logic [3:0]       tx_held,
    output logic [3:0]       tx_advance,
    output logic [127:0]     tx_next_desc,
    output logic             queue_cfg_req,
    output logic [8:0]       queue_cfg_sel,
    output logic             chan_cfg_req,
    output logic [15:0]      chan_cfg_cmd,
    input  wire logic        queue_regs_valid,
    output logic             action_request_irq_mask
);
    logic [31:0] global_command_register;
    logic        global_mode_register;
    logic [15:0] channel_configuration_register;
    logic [1:0]  global_status;
    logic [3:0]  poll_pulse;
    logic [3:0]  ar_count;
    logic        ar_busy;
    logic [8:0]  queue_sel;
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;
    logic        cmd_wr;
    logic        mode_wr;
    logic        status_wr;
    logic        cfg_wr;
    logic        ar_start;
    logic        ar_first;
    logic        ar_last;
    logic        queue_fail;
    logic        hold_mode;
    logic [31:0] held_next [0:3];
    logic [3:0]  held_int;
    logic [3:0]  advance_int;
    logic [3:0]  req_int;
    logic [3:0]  word_int;

    // Single-cycle access, so pready is always high in the access phase
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;
    assign addr_ok = paddr == dma_cmd_pkg::global_command_offset ||
                     paddr == dma_cmd_pkg::global_mode_offset ||
                     paddr == dma_cmd_pkg::global_status_offset ||
                     paddr == dma_cmd_pkg::channel_cfg_offset;
    assign queue_sel = {global_command_register[31:28], global_command_register[27:24],
                        global_command_register[dma_cmd_pkg::config_queue_cfg_bit]};

    // One decode per register keeps the write processes short
    assign cmd_wr    = wr_en && paddr == dma_cmd_pkg::global_command_offset;
    assign mode_wr   = wr_en && paddr == dma_cmd_pkg::global_mode_offset;
    assign status_wr = wr_en && paddr == dma_cmd_pkg::global_status_offset;
    assign cfg_wr    = wr_en && paddr == dma_cmd_pkg::channel_cfg_offset;

    // A request written while another runs is dropped, not queued
    assign ar_start = cmd_wr && !ar_busy && pwdata[dma_cmd_pkg::action_request_bit];
    assign ar_first = ar_busy && ar_count == dma_cmd_pkg::ar_exec_cycles;
    assign ar_last  = ar_busy && ar_count == 4'h1;

    // Queue setup without base and length programmed cannot succeed
    assign queue_fail = (|queue_cfg_sel) && !queue_regs_valid;

    // Mode select one turns pause flag and poll requests off together
    assign hold_mode = !global_mode_register;

    // Command register storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_command_register <= dma_cmd_pkg::command_reset;
        end else begin
            if (cmd_wr) begin
                global_command_register <= pwdata & dma_cmd_pkg::command_rw_mask;
                // Bit stays up while the request runs, never past its last cycle
                global_command_register[dma_cmd_pkg::action_request_bit] <=
                    ar_start || (ar_busy && !ar_last);
            end else if (ar_last) begin
                global_command_register[dma_cmd_pkg::action_request_bit] <= 1'b0;
            end
        end
    end

    // Poll bits never stored: they pulse for one cycle and read as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            poll_pulse <= 4'h0;
        end else begin
            poll_pulse <= 4'h0;
            if (cmd_wr && hold_mode) begin
                poll_pulse <= pwdata[dma_cmd_pkg::tx_poll_lsb +: 4];
            end
        end
    end

    // Mode register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_mode_register <= 1'b0;
        end else if (mode_wr) begin
            global_mode_register <= pwdata[dma_cmd_pkg::dma_control_select_bit];
        end
    end

    // Channel commands, issued again by every action request until rewritten
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_configuration_register <= 16'h0000;
        end else if (cfg_wr) begin
            channel_configuration_register <= pwdata[15:0];
        end
    end

    // Action request execution
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ar_busy       <= 1'b0;
            ar_count      <= 4'h0;
            queue_cfg_req <= 1'b0;
            queue_cfg_sel <= 9'h000;
            chan_cfg_req  <= 1'b0;
            chan_cfg_cmd  <= 16'h0000;
        end else begin
            queue_cfg_req <= 1'b0;
            chan_cfg_req  <= 1'b0;
            if (ar_start) begin
                ar_busy  <= 1'b1;
                ar_count <= dma_cmd_pkg::ar_exec_cycles;
            end else if (ar_busy) begin
                ar_count <= ar_count - 4'h1;
                // First busy cycle already sees the command bits just written
                if (ar_first) begin
                    queue_cfg_req <= |queue_sel;
                    queue_cfg_sel <= queue_sel;
                    chan_cfg_req  <= |channel_configuration_register;
                    chan_cfg_cmd  <= channel_configuration_register;
                end
                if (ar_last) begin
                    ar_busy <= 1'b0;
                end
            end
        end
    end

    // Outcome: fail when a queue is configured without valid base and length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_status <= 2'b00;
        end else begin
            if (status_wr) begin
                global_status <= global_status & ~pwdata[1:0];
            end
            // Set wins over a clear in the same cycle
            if (ar_last) begin
                if (queue_fail) begin
                    global_status[dma_cmd_pkg::ar_fail_bit] <= 1'b1;
                end else begin
                    global_status[dma_cmd_pkg::ar_done_bit] <= 1'b1;
                end
            end
        end
    end

    // APB response: zero wait states, error flagged with ready on unmapped words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
        end
    end

    // Read data captured in setup so it stands through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (paddr)
                dma_cmd_pkg::global_command_offset: prdata <= global_command_register;
                dma_cmd_pkg::global_mode_offset:    prdata <= {31'h0, global_mode_register};
                dma_cmd_pkg::global_status_offset:  prdata <= {30'h0, global_status};
                dma_cmd_pkg::channel_cfg_offset:
                    prdata <= {16'h0, channel_configuration_register};
                default:                            prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Loaded by the same write as the register bit, so both change together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            action_request_irq_mask <= 1'b1;
        end else if (cmd_wr) begin
            action_request_irq_mask <= pwdata[dma_cmd_pkg::irq_mask_bit];
        end
    end

    // Channel 0
    tx_poll_channel u_chan0 (
        .pclk             (pclk),
        .presetn          (presetn),
        .hold_mode        (hold_mode),
        .poll_cmd         (poll_pulse[0]),
        .desc_fetch_start (desc_fetch_start[0]),
        .mem_ack          (mem_ack[0]),
        .mem_rdata        (mem_rdata),
        .mem_req          (req_int[0]),
        .mem_word         (word_int[0]),
        .held             (held_int[0]),
        .advance          (advance_int[0]),
        .next_desc        (held_next[0])
    );

    // Channel 1
    tx_poll_channel u_chan1 (
        .pclk             (pclk),
        .presetn          (presetn),
        .hold_mode        (hold_mode),
        .poll_cmd         (poll_pulse[1]),
        .desc_fetch_start (desc_fetch_start[1]),
        .mem_ack          (mem_ack[1]),
        .mem_rdata        (mem_rdata),
        .mem_req          (req_int[1]),
        .mem_word         (word_int[1]),
        .held             (held_int[1]),
        .advance          (advance_int[1]),
        .next_desc        (held_next[1])
    );

    // Channel 2
    tx_poll_channel u_chan2 (
        .pclk             (pclk),
        .presetn          (presetn),
        .hold_mode        (hold_mode),
        .poll_cmd         (poll_pulse[2]),
        .desc_fetch_start (desc_fetch_start[2]),
        .mem_ack          (mem_ack[2]),
        .mem_rdata        (mem_rdata),
        .mem_req          (req_int[2]),
        .mem_word         (word_int[2]),
        .held             (held_int[2]),
        .advance          (advance_int[2]),
        .next_desc        (held_next[2])
    );

    // Channel 3
    tx_poll_channel u_chan3 (
        .pclk             (pclk),
        .presetn          (presetn),
        .hold_mode        (hold_mode),
        .poll_cmd         (poll_pulse[3]),
        .desc_fetch_start (desc_fetch_start[3]),
        .mem_ack          (mem_ack[3]),
        .mem_rdata        (mem_rdata),
        .mem_req          (req_int[3]),
        .mem_word         (word_int[3]),
        .held             (held_int[3]),
        .advance          (advance_int[3]),
        .next_desc        (held_next[3])
    );

    // Channel outputs are flops inside each channel
    assign tx_next_desc = {held_next[3], held_next[2], held_next[1], held_next[0]};

    assign mem_req    = req_int;
    assign mem_word   = word_int;
    assign tx_held    = held_int;
    assign tx_advance = advance_int;
endmodule : dma_global_command_logic

// ### tb/dma_cmd_properties.sv
`timescale 1ns/10ps
module dma_cmd_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [3:0]  mem_ack,
    input wire logic [3:0]  mem_req,
    input wire logic [3:0]  mem_word,
    input wire logic [3:0]  tx_held,
    input wire logic [3:0]  tx_advance,
    input wire logic        queue_cfg_req,
    input wire logic        action_request_irq_mask
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic cmd_sel;
    logic cmd_wr;
    assign cmd_sel = psel && penable && paddr == dma_cmd_pkg::global_command_offset;
    assign cmd_wr  = cmd_sel && pwrite && pready;

    AST_PREADY_AFTER_SETUP: assert property (psel && !penable |=> pready)
        else $error("no ready one cycle after setup");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_MASK_WRITE: assert property (
        cmd_wr |=> action_request_irq_mask == $past(pwdata[9]))
        else $error("mask bit not written");
    AST_MASK_HOLD: assert property (
        !cmd_wr |=> $stable(action_request_irq_mask))
        else $error("mask bit changed without write");
    AST_RESERVED_ZERO: assert property (
        cmd_sel && !pwrite && pready |-> prdata[8:1] == 8'h00)
        else $error("reserved bits not zero");
    AST_POLL_READS_ZERO: assert property (
        cmd_sel && !pwrite && pready |-> prdata[13:10] == 4'h0)
        else $error("poll bits did not self clear");
    AST_HELD_NO_ADVANCE: assert property (tx_held[0] |-> !tx_advance[0])
        else $error("held channel advanced");
    AST_ADVANCE_AFTER_WORD: assert property (
        tx_advance[0] |-> $past(mem_ack[0]) || $past(mem_ack[0], 2))
        else $error("advance without fetched word");
    AST_WORD1_AFTER_WORD0: assert property (
        mem_req[0] && mem_word[0] |-> $past(mem_ack[0]) || $past(mem_ack[0], 2))
        else $error("second word fetched out of order");
    AST_AR_QUEUE: assert property (
        cmd_wr && pwdata[0] && pwdata[21] |-> ##[1:8] queue_cfg_req)
        else $error("action request did not configure queue");

    COV_ADVANCE: cover property (tx_advance[0]);
    COV_QUEUE: cover property (queue_cfg_req);
    COV_ERR: cover property (pslverr);
endmodule : dma_cmd_checker

bind dma_global_command_logic dma_cmd_checker u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_ack(mem_ack),
    .mem_req(mem_req), .mem_word(mem_word), .tx_held(tx_held), .tx_advance(tx_advance),
    .queue_cfg_req(queue_cfg_req), .action_request_irq_mask(action_request_irq_mask));

// ### tb/host_mem_model.sv
`timescale 1ns/10ps
module host_mem_model (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [3:0]   mem_req,
    input  wire logic [3:0]   mem_word,
    input  wire logic [3:0]   hold_flag,
    input  wire logic [127:0] next_addr,
    input  wire logic         slow,
    output logic [3:0]        mem_ack,
    output logic [31:0]       mem_rdata
);
    int   ch;
    int   wait_n;
    logic wsel;
    // Idle data toggles so a stale word never looks fresh
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 4'h0;
            mem_rdata <= 32'h0;
            wait_n = 0;
        end else begin
            mem_ack <= 4'h0;
            mem_rdata <= ~mem_rdata;
            for (int i = 0; i < 4; i++) begin
                if (mem_req[i]) begin
                    ch = i;
                    wsel = mem_word[i];
                    wait_n = slow ? 6 : 1;
                end
            end
            if (wait_n == 1) begin
                mem_ack[ch] <= 1'b1;
                mem_rdata <= wsel ? next_addr[ch*32+:32] : {hold_flag[ch], 31'h0};
            end
            if (wait_n > 0) wait_n = wait_n - 1;
        end
    end
endmodule : host_mem_model

// ### tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, qvalid = 0, slow = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, mem_rdata, req_cnt = 0, q_cnt = 0, c_cnt = 0;
    logic [3:0] dstart = 4'h0, hold_flag = 4'h0, mem_ack, mem_req, mem_word, tx_held, tx_adv;
    logic [127:0] next_addr = {32'h0000_3c00, 32'h0000_2800, 32'h0000_1400, 32'h0000_0a00};
    logic [127:0] tx_next_desc;
    logic [15:0] ccmd;
    logic [8:0] qsel;
    logic pready, pslverr, qreq, creq, irq_mask;
    int bad_count = 0, n_tests = 0, cycles = 0;

    always #12.5 pclk = ~pclk;
    dma_global_command_logic u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .desc_fetch_start(dstart), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .mem_req(mem_req), .mem_word(mem_word), .tx_held(tx_held),
        .tx_advance(tx_adv), .tx_next_desc(tx_next_desc), .queue_cfg_req(qreq),
        .queue_cfg_sel(qsel), .chan_cfg_req(creq), .chan_cfg_cmd(ccmd),
        .queue_regs_valid(qvalid), .action_request_irq_mask(irq_mask));
    host_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
        .mem_word(mem_word), .hold_flag(hold_flag), .next_addr(next_addr), .slow(slow),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    always @(posedge pclk) begin
        req_cnt <= req_cnt + 32'($countones(mem_req));
        q_cnt <= q_cnt + 32'(qreq);
        c_cnt <= c_cnt + 32'(creq);
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb

    task automatic regs_test();
        logic [31:0] r;
        logic e;
        apb(0, 12'h000, 0, r, e);
        check(r, 32'h0000_0200);
        check({31'h0, irq_mask}, 1);
        apb(1, 12'h000, 32'h0000_01fe, r, e);
        apb(0, 12'h000, 0, r, e);
        check(r, 32'h0);
        check({31'h0, irq_mask}, 32'h0);
        apb(1, 12'h000, 32'h0000_0200, r, e);
        apb(0, 12'hffc, 0, r, e);
        check({31'h0, e}, 1);
    endtask : regs_test

    task automatic poll_test(input int ch);
        logic [31:0] r, c0, cmd;
        logic e;
        int n = 0;
        cmd = 32'h0000_0200 | (32'h1 << (10 + ch));
        slow <= ch[0];
        hold_flag <= hold_flag | (4'h1 << ch);
        @(posedge pclk) dstart <= 4'h1 << ch;
        @(posedge pclk) dstart <= 4'h0;
        while (tx_held[ch] !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        check({31'h0, tx_held[ch]}, 1);
        apb(1, dma_cmd_pkg::global_mode_offset, 32'h1, r, e);
        c0 = req_cnt;
        apb(1, 12'h000, cmd, r, e);
        repeat (12) @(posedge pclk);
        check(req_cnt - c0, 0);
        apb(1, dma_cmd_pkg::global_mode_offset, 32'h0, r, e);
        hold_flag <= hold_flag & ~(4'h1 << ch);
        c0 = req_cnt;
        apb(1, 12'h000, cmd, r, e);
        n = 0;
        while (tx_adv[ch] !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        @(posedge pclk);
        check(req_cnt - c0, 2);
        check(tx_next_desc[ch*32+:32], next_addr[ch*32+:32]);
        c0 = req_cnt;
        apb(1, 12'h000, cmd, r, e);
        repeat (12) @(posedge pclk);
        check(req_cnt - c0, 0);
    endtask : poll_test

    task automatic ar_test(input logic ok, input logic [31:0] cmd, input logic [31:0] q_exp);
        logic [31:0] r, q0, c0;
        logic e;
        qvalid <= ok;
        q0 = q_cnt;
        c0 = c_cnt;
        apb(1, 12'h000, cmd, r, e);
        apb(0, 12'h000, 0, r, e);
        check({31'h0, r[0]}, 1);
        repeat (10) @(posedge pclk);
        apb(0, 12'h000, 0, r, e);
        check({31'h0, r[0]}, 0);
        apb(0, dma_cmd_pkg::global_status_offset, 0, r, e);
        check({30'h0, r[1:0]}, {30'h0, !ok, ok});
        apb(1, dma_cmd_pkg::global_status_offset, 32'h3, r, e);
        check(q_cnt - q0, q_exp);
        check(c_cnt - c0, 1);
    endtask : ar_test

    initial begin
        logic [31:0] r;
        logic e;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        regs_test();
        for (int ch = 0; ch < 4; ch++) poll_test(ch);
        apb(1, dma_cmd_pkg::channel_cfg_offset, 32'h0000_1234, r, e);
        ar_test(1, 32'h0020_0201, 1);
        check({23'h0, qsel}, 32'h1);
        ar_test(1, 32'h0000_0201, 0);
        check({16'h0, ccmd}, 32'h0000_1234);
        ar_test(0, 32'h0020_0201, 1);
        finish_test();
    end
endmodule : tb_top
